// file: inc/otl_pkg.sv
// constants and types shared by the overcurrent trip logic
package otl_pkg;

  // ********************************
  // ** clock and time base
  // ********************************
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC      = CLK_MHZ * TICK_US;

  // ********************************
  // ** current bands, tenths of rated current
  // ********************************
  localparam logic [7:0] BAND_1P1       = 8'h0B;
  localparam logic [7:0] BAND_1P3       = 8'h0D;
  localparam logic [7:0] BAND_1P5       = 8'h0F;
  localparam logic [7:0] BAND_1P8       = 8'h12;
  localparam logic [7:0] BAND_2P0       = 8'h14;

  // ********************************
  // ** trip times in ms
  // ********************************
  localparam logic [15:0] T_B1_FAST     = 16'h1B58;
  localparam logic [15:0] T_B1_STD      = 16'h2710;
  localparam logic [15:0] T_B1_SLOW     = 16'h3A98;
  localparam logic [15:0] T_B3_FAST     = 16'h02BC;
  localparam logic [15:0] T_B3_STD      = 16'h03E8;
  localparam logic [15:0] T_B3_SLOW     = 16'h05DC;
  localparam logic [15:0] T_B4_FAST     = 16'h0046;
  localparam logic [15:0] T_B4_STD      = 16'h0064;
  localparam logic [15:0] T_B4_SLOW     = 16'h0096;
  localparam logic [15:0] T_B5_FAST     = 16'h0001;
  localparam logic [15:0] T_B5_STD      = 16'h0008;
  localparam logic [15:0] T_B5_SLOW     = 16'h000C;
  localparam logic [15:0] T_ZERO        = 16'h0000;
  localparam logic [15:0] T_ONE         = 16'h0001;

  // ********************************
  // ** types
  // ********************************
  typedef enum logic [1:0] {
    OTL_FAST,
    OTL_STD,
    OTL_SLOW
  } otl_speed_t;

  typedef enum logic [1:0] {
    OTL_CAUSE_NONE,
    OTL_CAUSE_CURVE,
    OTL_CAUSE_HWLIM,
    OTL_CAUSE_INTEG
  } otl_cause_t;

  typedef enum {
    ST_OFF,
    ST_ON,
    ST_TRIP
  } otl_state_t;

endpackage : otl_pkg

// file: inc/otl_curve_if.sv
// interface between trip controller and curve lookup
`timescale 1ns/1ns
`default_nettype none
interface otl_curve_if;
  import otl_pkg::*;
  logic [7:0]  load_x10;   // current in tenths of rated
  otl_speed_t  speed;      // effective speed
  logic        over;       // current in a trip band
  logic [15:0] limit_ms;   // trip time for the band
  modport ctrl (output load_x10, output speed, input over, input limit_ms);
  modport lut  (input load_x10, input speed, output over, output limit_ms);
endinterface : otl_curve_if
`default_nettype wire

// file: core/otl_curve.sv
// tripping characteristic lookup
`timescale 1ns/1ns
`default_nettype none
module otl_curve
  import otl_pkg::*;
(
  otl_curve_if.lut cv  // load current and speed in, over flag and trip time out
);
  logic [15:0] t_fast;
  logic [15:0] t_std;
  logic [15:0] t_slow;

  always_comb begin
    cv.over = 1'b1;
    if (cv.load_x10 >= BAND_2P0) begin // see RL3
      t_fast = T_B5_FAST;
      t_std  = T_B5_STD;
      t_slow = T_B5_SLOW;
    end else if (cv.load_x10 >= BAND_1P8) begin // see RL2
      t_fast = T_B4_FAST;
      t_std  = T_B4_STD;
      t_slow = T_B4_SLOW;
    end else if (cv.load_x10 >= BAND_1P5) begin // see RL2
      t_fast = T_B3_FAST;
      t_std  = T_B3_STD;
      t_slow = T_B3_SLOW;
    end else if (cv.load_x10 >= BAND_1P3) begin
      // halved times of the lowest band, see RL1
      t_fast = T_B1_FAST >> 1;
      t_std  = T_B1_STD >> 1;
      t_slow = T_B1_SLOW >> 1;
    end else begin // see RL1
      t_fast = T_B1_FAST;
      t_std  = T_B1_STD;
      t_slow = T_B1_SLOW;
      cv.over = (cv.load_x10 >= BAND_1P1); // see RL11
    end
    case (cv.speed)
      OTL_FAST: cv.limit_ms = t_fast;
      OTL_SLOW: cv.limit_ms = t_slow;
      default:  cv.limit_ms = t_std;
    endcase
  end
endmodule : otl_curve
`default_nettype wire

// file: core/otl_trip.sv
// trip controller for one protected output channel
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RL1: from 1.1 to 1.2 times rated the channel trips after 7000/10000/15000 ms, half that at 1.3-1.4.
// RL2: from 1.5 to 1.7 times rated it trips after 700/1000/1500 ms, and 70/100/150 ms at 1.8-1.9.
// RL3: at twice rated or more it trips after 1, 8 or 12 ms for fast, standard or slow.
// RL4: a standard-only variant ignores fast and slow selections and uses standard.
// RL5: curve tripping is armed only once the output has been switched on successfully.
// RL6: an overload seen at switch-on makes the hardware limits shut down and keep the output off.
// RL7: while on, a hardware power or current limit trips after a fixed delay, not the curve time.
// RL8: the power and current limit check is active whether or not the output is on.
// RL9: a load integral builds up over repeated overcurrent pulses and trips when over its limit.
// RL10: a load switched on downstream of an already-on output is judged by the curve.
// RL11: below 1.1 times rated no curve timer runs, and a running one restarts.
// RL12: after any trip the output stays off and the trip flag stays set until re-enabled.
module otl_trip
  import otl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,   // cycles per 1 ms tick
  parameter int unsigned HW_DELAY_MS = 1,          // fixed hardware-limit delay
  parameter int unsigned INTEG_LIMIT = 40000,      // load integral trip level
  parameter bit          STD_ONLY    = 1'b0        // standard speed only variant
) (
  input  wire logic       sys_clk,      // 250 MHz clock
  input  wire logic       srst,         // synchronous reset, high
  input  wire logic       on_cmd,       // request output on (level)
  input  wire logic       rearm,        // re-enable after trip (pulse)
  input  wire logic [1:0] speed_sel,    // 0 fast, 1 standard, 2 slow
  input  wire logic [7:0] load_x10,     // current, tenths of rated
  input  wire logic       hw_limit,     // power or current limit exceeded
  output logic            out_en_r,     // channel output switch
  output logic            trip_r,       // sticky trip flag
  output logic [1:0]      cause_r       // cause of last trip
);

  // ********************************
  // ** lookup and speed selection
  // ********************************
  otl_curve_if cv ();
  otl_curve u_curve (.cv(cv.lut));

  assign cv.load_x10 = load_x10;
  always_comb begin
    if (STD_ONLY || speed_sel == 2'h3)  // see RL4
      cv.speed = OTL_STD;
    else
      cv.speed = otl_speed_t'(speed_sel);
  end

  // ********************************
  // ** millisecond tick
  // ********************************
  logic [31:0] tick_cnt_r;
  logic        tick;
  assign tick = (tick_cnt_r == TICK_CYCLES - 1);
  always_ff @(posedge sys_clk) begin
    if (srst || tick)
      tick_cnt_r <= 32'h0000_0000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end

  // ********************************
  // ** state machine
  // ********************************
  otl_state_t  state_r;
  otl_state_t  state_nxt;
  logic [15:0] curve_ms_r;
  logic [15:0] hw_ms_r;
  logic [31:0] integ_r;
  logic        curve_hit;
  logic        hw_hit;
  logic        integ_hit;

  assign curve_hit = (state_r == ST_ON) && cv.over && tick &&
                     (curve_ms_r + T_ONE >= cv.limit_ms);
  assign hw_hit    = hw_limit && (state_r == ST_ON) && tick &&
                     (hw_ms_r + T_ONE >= 16'(HW_DELAY_MS));   // see RL7
  assign integ_hit = (state_r == ST_ON) && (integ_r > INTEG_LIMIT); // see RL9

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (on_cmd && hw_limit)          // see RL6, RL8
          state_nxt = ST_TRIP;
        else if (on_cmd)
          state_nxt = ST_ON;
      end
      ST_ON: begin
        if (!on_cmd)
          state_nxt = ST_OFF;
        else if (curve_hit || hw_hit || integ_hit)
          state_nxt = ST_TRIP;
      end
      ST_TRIP: begin
        if (rearm)                       // see RL12
          state_nxt = ST_OFF;
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  // ********************************
  // ** curve timer, runs only while on
  // ********************************
  always_ff @(posedge sys_clk) begin
    if (srst || state_r != ST_ON || !cv.over)  // see RL5, RL10, RL11
      curve_ms_r <= T_ZERO;
    else if (tick && curve_ms_r != 16'hFFFF)
      curve_ms_r <= curve_ms_r + T_ONE;
  end

  // ********************************
  // ** fixed hardware-limit timer
  // ********************************
  always_ff @(posedge sys_clk) begin
    if (srst || state_r != ST_ON || !hw_limit)  // see RL7
      hw_ms_r <= T_ZERO;
    else if (tick && hw_ms_r != 16'hFFFF)
      hw_ms_r <= hw_ms_r + T_ONE;
  end

  // ********************************
  // ** load integral, leaks only below 1.1 rated
  // ********************************
  always_ff @(posedge sys_clk) begin
    if (srst || state_r == ST_TRIP)
      integ_r <= 32'h0000_0000;
    else if (tick && load_x10 > BAND_1P1)  // see RL9
      integ_r <= integ_r + 32'(load_x10 - BAND_1P1);
    else if (tick && load_x10 < BAND_1P1 && integ_r != 32'h0000_0000)
      integ_r <= integ_r - 32'h0000_0001;
  end

  // ********************************
  // ** outputs
  // ********************************
  always_ff @(posedge sys_clk) begin
    if (srst)
      out_en_r <= 1'b0;
    else
      out_en_r <= (state_nxt == ST_ON);  // see RL6, RL12
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trip_r  <= 1'b0;
      cause_r <= OTL_CAUSE_NONE;
    end else if (state_r != ST_TRIP && state_nxt == ST_TRIP) begin  // see RL12
      trip_r <= 1'b1;
      if (state_r == ST_OFF || hw_hit)
        cause_r <= OTL_CAUSE_HWLIM;
      else if (curve_hit)
        cause_r <= OTL_CAUSE_CURVE;
      else
        cause_r <= OTL_CAUSE_INTEG;
    end else if (state_r == ST_TRIP && rearm) begin
      trip_r  <= 1'b0;
      cause_r <= OTL_CAUSE_NONE;
    end
  end

  // ********************************
  // ** checks
  // ********************************
  sequence s_hw_fire;
    ##1 (state_r == ST_TRIP && cause_r == OTL_CAUSE_HWLIM);
  endsequence
  sequence s_rearm_done;
    ##1 (state_r == ST_OFF && !trip_r && cause_r == OTL_CAUSE_NONE);
  endsequence
  sequence s_curve_fire;
    ##1 (state_r == ST_TRIP && cause_r == OTL_CAUSE_CURVE);
  endsequence

  a_off_when_trip: assert property (@(posedge sys_clk) disable iff (srst) // see RL12
    trip_r && !rearm |=> !out_en_r)
    else $error("output on while tripped");
  a_trip_sticky: assert property (@(posedge sys_clk) disable iff (srst) // see RL12
    trip_r && !rearm |=> trip_r)
    else $error("trip flag dropped");
  a_rearm_clear: assert property (@(posedge sys_clk) disable iff (srst) // see RL12
    trip_r && rearm |-> s_rearm_done)
    else $error("rearm left channel tripped");
  a_switchon_block: assert property (@(posedge sys_clk) disable iff (srst) // see RL6
    state_r == ST_OFF && on_cmd && hw_limit |=> trip_r && !out_en_r)
    else $error("overloaded switch-on not blocked");
  a_switchon_ok: assert property (@(posedge sys_clk) disable iff (srst) // see RL8
    state_r == ST_OFF && on_cmd && !hw_limit |=> out_en_r && !trip_r)
    else $error("clean switch-on refused");
  a_no_curve_low: assert property (@(posedge sys_clk) disable iff (srst) // see RL11
    load_x10 < BAND_1P1 |=> curve_ms_r == T_ZERO)
    else $error("curve timer below band");
  a_curve_armed: assert property (@(posedge sys_clk) disable iff (srst) // see RL5
    state_r != ST_ON |=> curve_ms_r == T_ZERO)
    else $error("curve timer while off");
  a_curve_cause: assert property (@(posedge sys_clk) disable iff (srst) // see RL10
    curve_hit && on_cmd && !hw_hit |-> s_curve_fire)
    else $error("curve trip cause wrong");
  a_std_only: assert property (@(posedge sys_clk) disable iff (srst) // see RL4
    STD_ONLY || speed_sel == 2'h1 || speed_sel == 2'h3 |-> cv.speed == OTL_STD)
    else $error("speed not standard");
  a_band_half: assert property (@(posedge sys_clk) disable iff (srst) // see RL1
    load_x10 >= BAND_1P3 && load_x10 < BAND_1P5 && cv.speed == OTL_STD
    |-> cv.limit_ms + cv.limit_ms == T_B1_STD)
    else $error("halved band time wrong");
  a_band_mid: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
    load_x10 >= BAND_1P8 && load_x10 < BAND_2P0 && cv.speed == OTL_FAST
    |-> cv.limit_ms == T_B4_FAST)
    else $error("upper band time wrong");
  a_curve_time: assert property (@(posedge sys_clk) disable iff (srst) // see RL3
    load_x10 >= BAND_2P0 && cv.speed == OTL_SLOW |-> cv.limit_ms == T_B5_SLOW)
    else $error("top band time wrong");
  a_hw_cause: assert property (@(posedge sys_clk) disable iff (srst) // see RL7
    hw_hit && on_cmd |-> s_hw_fire)
    else $error("hardware trip cause wrong");
  a_integ_trip: assert property (@(posedge sys_clk) disable iff (srst) // see RL9
    integ_hit && on_cmd |=> trip_r)
    else $error("integral trip missed");

endmodule : otl_trip
`default_nettype wire

// file: sim/otl_load_model.sv
// behavioural protected load circuit on the channel output
`timescale 1ns/1ns
`default_nettype none
module otl_load_model (
  input  wire logic       sys_clk,     // clock
  input  wire logic       out_en,      // channel output switch
  input  wire logic [7:0] demand_x10,  // current the load would draw
  input  wire logic       short_ckt,   // hard short on the line
  output logic      [7:0] load_x10,    // current seen by the channel
  output logic            hw_limit     // limiter stage overloaded
);
  // current flows only through a closed switch
  always_ff @(posedge sys_clk) begin
    load_x10 <= out_en ? demand_x10 : 8'h00;
  end
  // a short loads the limiter even while the switch is open
  always_ff @(posedge sys_clk) begin
    hw_limit <= short_ckt;
  end
endmodule : otl_load_model
`default_nettype wire

// file: sim/overcurrent_trip_logic_tb.sv
// self-checking bench for the overcurrent trip logic
`timescale 1ns/1ns
`default_nettype none
module overcurrent_trip_logic_tb;
  import otl_pkg::*;
  localparam int unsigned T    = 10;    // cycles per ms tick, shortened
  localparam int unsigned ILIM = 1000;  // load integral trip level
  logic       sys_clk, srst, on_cmd, rearm, short_ckt, hw_limit, out_en_r, trip_r;
  logic [1:0] speed_sel, cause_r;
  logic [7:0] demand, load_x10;
  int         mismatches = 0;
  int         cmp_count  = 0;
  int         cyc        = 0;
  otl_trip #(.TICK_CYCLES(T), .HW_DELAY_MS(1), .INTEG_LIMIT(ILIM), .STD_ONLY(1'b0)) dut (
    .sys_clk(sys_clk), .srst(srst), .on_cmd(on_cmd), .rearm(rearm), .speed_sel(speed_sel),
    .load_x10(load_x10), .hw_limit(hw_limit), .out_en_r(out_en_r), .trip_r(trip_r),
    .cause_r(cause_r));
  otl_load_model load (.sys_clk(sys_clk), .out_en(out_en_r), .demand_x10(demand),
    .short_ckt(short_ckt), .load_x10(load_x10), .hw_limit(hw_limit));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0b seen %0b", nm, e, g);
    end
  endtask : chk1
  task automatic chk2(input string nm, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk2
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic wait_trip(output int n);
    n = 0;
    while (trip_r !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask : wait_trip
  // ********************************
  // ** scenarios
  // ********************************
  // checks the sticky trip, then rearms and leaves the channel off
  task automatic finish_trip(input string nm, input logic [1:0] c);
    @(posedge sys_clk);
    demand    <= 8'h00;
    short_ckt <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    chk1("trip held", 1'b1, trip_r);
    chk1("output held off", 1'b0, out_en_r);
    chk2("cause", c, cause_r);
    @(posedge sys_clk);
    rearm <= 1'b1;
    @(posedge sys_clk);
    rearm <= 1'b0;
    #1;
    chk1("trip cleared", 1'b0, trip_r);
    chk2("cause cleared", OTL_CAUSE_NONE, cause_r);
    @(posedge sys_clk);
    on_cmd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    $display("test %s done", nm);
  endtask : finish_trip
  task automatic t_curve(input string nm, input logic [1:0] sp, input logic [7:0] ld,
                         input int lim);
    int n;
    @(posedge sys_clk);
    speed_sel <= sp;
    demand    <= ld;
    on_cmd    <= 1'b1;
    wait_trip(n);
    chk_rng("curve time", (lim - 1) * T, lim * T + 6, n);
    finish_trip(nm, OTL_CAUSE_CURVE);
  endtask : t_curve
  task automatic t_hw_on();
    @(posedge sys_clk);
    short_ckt <= 1'b1;
    repeat (2) @(posedge sys_clk);
    on_cmd <= 1'b1;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      chk1("output at switch-on", 1'b0, out_en_r);
    end
    finish_trip("hw at switch-on", OTL_CAUSE_HWLIM);
  endtask : t_hw_on
  task automatic t_hw_run();
    int n;
    @(posedge sys_clk);
    speed_sel <= OTL_STD;
    demand    <= 8'h0D;
    on_cmd    <= 1'b1;
    repeat (10 * T) @(posedge sys_clk);
    #1;
    chk1("no early trip at 1.3x", 1'b0, trip_r);
    @(posedge sys_clk);
    demand <= 8'h0A;
    repeat (30 * T) @(posedge sys_clk);
    #1;
    chk1("no trip below band", 1'b0, trip_r);
    chk1("output on", 1'b1, out_en_r);
    @(posedge sys_clk);
    short_ckt <= 1'b1;
    wait_trip(n);
    chk_rng("hw limit delay", 1, 2 * T + 4, n);
    finish_trip("hw while on", OTL_CAUSE_HWLIM);
  endtask : t_hw_run
  task automatic t_restart();
    int n;
    @(posedge sys_clk);
    speed_sel <= OTL_STD;
    demand    <= 8'h14;
    on_cmd    <= 1'b1;
    repeat (5 * T) @(posedge sys_clk);
    demand <= 8'h0A;
    repeat (2 * T) @(posedge sys_clk);
    demand <= 8'h14;
    wait_trip(n);
    chk_rng("restarted timer", 6 * T, 8 * T + 6, n);
    finish_trip("timer restart", OTL_CAUSE_CURVE);
  endtask : t_restart
  // pulses stay short of the curve time, so only the integral can trip
  task automatic t_integ();
    @(posedge sys_clk);
    speed_sel <= OTL_FAST;
    on_cmd    <= 1'b1;
    for (int p = 0; p < 4 && trip_r !== 1'b1; p++) begin
      demand <= 8'h13;
      repeat (60 * T) @(posedge sys_clk);
      demand <= 8'h0A;
      repeat (T + 1) @(posedge sys_clk);
    end
    finish_trip("load integral", OTL_CAUSE_INTEG);
  endtask : t_integ
  initial begin
    srst      = 1'b1;
    on_cmd    = 1'b0;
    rearm     = 1'b0;
    speed_sel = 2'h1;
    demand    = 8'h00;
    short_ckt = 1'b0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk1("output after reset", 1'b0, out_en_r);
    chk1("trip after reset", 1'b0, trip_r);
    t_curve("fast 2x", OTL_FAST, 8'h14, 1);
    t_curve("std 2x", OTL_STD, 8'h14, 8);
    t_curve("slow 2x", OTL_SLOW, 8'h14, 12);
    t_curve("fast 1.8x", OTL_FAST, 8'h12, 70);
    t_curve("std 1.8x", OTL_STD, 8'h12, 100);
    t_hw_on();
    t_hw_run();
    t_restart();
    t_integ();
    give_verdict();
  end
endmodule : overcurrent_trip_logic_tb
`default_nettype wire
